// ==== core/acc_alu_pkg.sv ====
// Purpose: Shared constants and types for the accumulator arithmetic block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   Flags sit in the low nibble of the flag register

package acc_alu_pkg;

    // ****************************************
    // Bus and memory sizes
    // ****************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int MEM_DEPTH = 16;
    localparam int MEM_AW = 4;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_OPND = 8'h04;
    localparam logic [7:0] OFF_WORK = 8'h08;
    localparam logic [7:0] OFF_FLAGS = 8'h0C;
    localparam logic [7:0] OFF_STACK = 8'h10;
    localparam logic [7:0] OFF_MEMWIN = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int OPND_IMM_LSB = 0;
    localparam int OPND_ADDR_LSB = 8;
    localparam int FLAG_Z = 0;
    localparam int FLAG_C = 1;
    localparam int FLAG_AC = 2;
    localparam int FLAG_OV = 3;
    localparam int STAT_BUSY = 0;
    localparam int STAT_BADOP = 1;

    // ****************************************
    // Reset values and steps
    // ****************************************
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [3:0] SP_RST = 4'h0;
    localparam logic [11:0] OPND_RST = 12'h000;
    localparam logic [3:0] SP_STEP = 4'h2;

    // ****************************************
    // Operation codes and states
    // ****************************************
    typedef enum logic [4:0] {
        OP_SWAP = 5'h00, OP_PUSH = 5'h01, OP_POP = 5'h02, OP_ADD_AI = 5'h03,
        OP_ADD_AM = 5'h04, OP_ADD_MA = 5'h05, OP_ADDC_AM = 5'h06, OP_ADDC_MA = 5'h07,
        OP_ADDC_A = 5'h08, OP_ADDC_M = 5'h09, OP_SUB_AI = 5'h0A, OP_SUB_AM = 5'h0B,
        OP_SUB_MA = 5'h0C, OP_SUBC_AM = 5'h0D, OP_SUBC_MA = 5'h0E, OP_SUBC_A = 5'h0F,
        OP_SUBC_M = 5'h10, OP_INC_M = 5'h11, OP_DEC_M = 5'h12, OP_CLR_M = 5'h13
    } op_t;

    typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_EXEC = 1'b1} state_t;

    typedef enum logic [2:0] {
        SEL_CMD = 3'h0, SEL_OPND = 3'h1, SEL_WORK = 3'h2, SEL_FLAGS = 3'h3,
        SEL_STACK = 3'h4, SEL_MEMWIN = 3'h5, SEL_STATUS = 3'h6, SEL_NONE = 3'h7
    } reg_sel_t;

endpackage : acc_alu_pkg

// ==== core/byte_adder.sv ====
// Purpose: 8-bit adder and subtracter with the four arithmetic flags
// Assumes: Subtraction is done as addition of the complement
// Notes:   Carry and half carry read as borrows when subtracting

`timescale 1ns/1ns
`default_nettype none

module byte_adder (
    input wire logic [7:0] a_in,
    input wire logic [7:0] b_in,
    input wire logic carry_in,
    input wire logic sub_mode,
    output logic [7:0] result,
    output logic [3:0] flags
);
    import acc_alu_pkg::*;

    logic [7:0] b_eff;
    logic cin_eff;
    logic [8:0] full_sum;
    logic [4:0] low_sum;

    // ****************************************
    // Sum with complement for subtraction
    // ****************************************
    always_comb begin
        b_eff = sub_mode ? ~b_in : b_in;
        cin_eff = sub_mode ? ~carry_in : carry_in;
        full_sum = {1'b0, a_in} + {1'b0, b_eff} + {8'h00, cin_eff};
        low_sum = {1'b0, a_in[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_eff};
        result = full_sum[7:0];
        flags = 4'h0;
        flags[FLAG_Z] = (full_sum[7:0] == 8'h00); // see RULE_19
        flags[FLAG_C] = full_sum[8] ^ sub_mode; // see RULE_19
        flags[FLAG_AC] = low_sum[4] ^ sub_mode; // see RULE_19
        flags[FLAG_OV] = (a_in[7] == b_eff[7]) && (full_sum[7] != a_in[7]); // see RULE_19
    end

endmodule : byte_adder

`default_nettype wire

// ==== core/acc_alu.sv ====
// Purpose: Accumulator exchange, stack save/restore and arithmetic over APB
// Assumes: Data memory of 16 bytes held inside, reached by a window register
// Notes:   A write to the command register runs one operation in the next cycle
//
// Behaviour
// (RULE_01) Swap exchanges work register and memory byte; flags untouched.
// (RULE_02) Save writes work register and flags at stack index, then index plus two.
// (RULE_03) Restore lowers stack index by two, then reloads work register and flags.
// (RULE_04) Add immediate to work register, result in work register, flags updated.
// (RULE_05) Add memory and work register, result to register or memory, flags updated.
// (RULE_06) Add memory, work register and carry, result to register or memory.
// (RULE_07) Add carry alone to work register, flags updated.
// (RULE_08) Add carry alone to memory byte, written back, flags updated.
// (RULE_09) Work register minus immediate via complement addition, flags updated.
// (RULE_10) Work register minus memory byte into work register, flags updated.
// (RULE_11) Memory byte minus work register back into memory, flags updated.
// (RULE_12) Work register minus memory minus carry into work register.
// (RULE_13) Memory minus work register minus carry back into memory.
// (RULE_14) Subtract carry alone from work register, flags updated.
// (RULE_15) Subtract carry alone from memory byte, written back, flags updated.
// (RULE_16) Increment memory byte in place, flags updated.
// (RULE_17) Decrement memory byte in place, flags updated.
// (RULE_18) Clear memory byte to zero; flags untouched.
// (RULE_19) Flags: zero, carry or borrow from bit 7, half carry from bit 3, overflow.
//
// The register offsets and the APB register port are this design's own decisions.

`timescale 1ns/1ns
`default_nettype none

module acc_alu (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [acc_alu_pkg::ADDR_W-1:0] paddr,
    input wire logic [acc_alu_pkg::DATA_W-1:0] pwdata,
    output logic [acc_alu_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr
);
    import acc_alu_pkg::*;

    // ****************************************
    // Address decode
    // ****************************************
    function automatic reg_sel_t reg_sel(input logic [ADDR_W-1:0] addr);
        unique case (addr)
            OFF_CMD: return SEL_CMD;
            OFF_OPND: return SEL_OPND;
            OFF_WORK: return SEL_WORK;
            OFF_FLAGS: return SEL_FLAGS;
            OFF_STACK: return SEL_STACK;
            OFF_MEMWIN: return SEL_MEMWIN;
            OFF_STATUS: return SEL_STATUS;
            default: return SEL_NONE;
        endcase
    endfunction : reg_sel

    state_t state_q, state_d;
    op_t op_q, op_d;
    logic [11:0] opnd_q, opnd_d;
    logic [7:0] work_q, work_d;
    logic [3:0] flags_q, flags_d;
    logic [3:0] sp_q, sp_d;
    logic bad_q, bad_d;
    logic [7:0] mem_q [MEM_DEPTH];
    logic [7:0] mem_d [MEM_DEPTH];
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [DATA_W-1:0] prdata_q, prdata_d;
    logic exec;
    logic wr_fire;
    reg_sel_t sel;
    logic [MEM_AW-1:0] addr;
    logic [7:0] imm;
    logic [7:0] mem_rd;
    logic [3:0] sp_nx;
    logic [3:0] sp_dn;
    logic [DATA_W-1:0] rd_val;
    logic [7:0] alu_a, alu_b, alu_res;
    logic alu_cin, alu_sub, is_arith, to_mem;
    logic [3:0] alu_flags;

    // ****************************************
    // Shared decode and addressing
    // ****************************************
    assign exec = (state_q == ST_EXEC);
    assign sel = reg_sel(paddr);
    assign wr_fire = psel && penable && pready_q && pwrite;
    assign addr = opnd_q[OPND_ADDR_LSB +: MEM_AW];
    assign imm = opnd_q[OPND_IMM_LSB +: 8];
    assign mem_rd = mem_q[addr];
    assign sp_nx = sp_q + 4'h1;
    assign sp_dn = sp_q - SP_STEP;

    // ****************************************
    // Operand selection per operation
    // ****************************************
    always_comb begin
        alu_a = work_q;
        alu_b = 8'h00;
        alu_cin = 1'b0;
        alu_sub = 1'b0;
        is_arith = 1'b1;
        to_mem = 1'b0;
        case (op_q)
            OP_ADD_AI: alu_b = imm; // see RULE_04
            OP_ADD_AM: alu_b = mem_rd; // see RULE_05
            OP_ADD_MA: begin // see RULE_05
                alu_b = mem_rd;
                to_mem = 1'b1;
            end
            OP_ADDC_AM: begin // see RULE_06
                alu_b = mem_rd;
                alu_cin = flags_q[FLAG_C];
            end
            OP_ADDC_MA: begin // see RULE_06
                alu_b = mem_rd;
                alu_cin = flags_q[FLAG_C];
                to_mem = 1'b1;
            end
            OP_ADDC_A: alu_cin = flags_q[FLAG_C]; // see RULE_07
            OP_ADDC_M: begin // see RULE_08
                alu_a = mem_rd;
                alu_cin = flags_q[FLAG_C];
                to_mem = 1'b1;
            end
            OP_SUB_AI: begin // see RULE_09
                alu_b = imm;
                alu_sub = 1'b1;
            end
            OP_SUB_AM: begin // see RULE_10
                alu_b = mem_rd;
                alu_sub = 1'b1;
            end
            OP_SUB_MA: begin // see RULE_11
                alu_a = mem_rd;
                alu_b = work_q;
                alu_sub = 1'b1;
                to_mem = 1'b1;
            end
            OP_SUBC_AM: begin // see RULE_12
                alu_b = mem_rd;
                alu_cin = flags_q[FLAG_C];
                alu_sub = 1'b1;
            end
            OP_SUBC_MA: begin // see RULE_13
                alu_a = mem_rd;
                alu_b = work_q;
                alu_cin = flags_q[FLAG_C];
                alu_sub = 1'b1;
                to_mem = 1'b1;
            end
            OP_SUBC_A: begin // see RULE_14
                alu_cin = flags_q[FLAG_C];
                alu_sub = 1'b1;
            end
            OP_SUBC_M: begin // see RULE_15
                alu_a = mem_rd;
                alu_cin = flags_q[FLAG_C];
                alu_sub = 1'b1;
                to_mem = 1'b1;
            end
            OP_INC_M: begin // see RULE_16
                alu_a = mem_rd;
                alu_b = 8'h01;
                to_mem = 1'b1;
            end
            OP_DEC_M: begin // see RULE_17
                alu_a = mem_rd;
                alu_b = 8'h01;
                alu_sub = 1'b1;
                to_mem = 1'b1;
            end
            default: is_arith = 1'b0;
        endcase
    end

    // Shared adder for every arithmetic operation
    byte_adder u_adder (
        .a_in(alu_a),
        .b_in(alu_b),
        .carry_in(alu_cin),
        .sub_mode(alu_sub),
        .result(alu_res),
        .flags(alu_flags)
    );

    // ****************************************
    // Register writes and operation execution
    // ****************************************
    always_comb begin
        state_d = state_q;
        op_d = op_q;
        opnd_d = opnd_q;
        work_d = work_q;
        flags_d = flags_q;
        sp_d = sp_q;
        bad_d = bad_q;
        mem_d = mem_q;
        unique case (state_q)
            ST_IDLE: begin
                if (wr_fire) begin
                    case (sel)
                        SEL_CMD: begin
                            op_d = op_t'(pwdata[4:0]);
                            state_d = ST_EXEC;
                        end
                        SEL_OPND: opnd_d = pwdata[11:0];
                        SEL_WORK: work_d = pwdata[7:0];
                        SEL_FLAGS: flags_d = pwdata[3:0];
                        SEL_STACK: sp_d = pwdata[3:0];
                        SEL_MEMWIN: mem_d[addr] = pwdata[7:0];
                        default: ;
                    endcase
                end
            end
            ST_EXEC: begin
                state_d = ST_IDLE;
                bad_d = 1'b0;
                if (is_arith) begin
                    flags_d = alu_flags; // see RULE_19
                    if (to_mem) begin
                        mem_d[addr] = alu_res;
                    end else begin
                        work_d = alu_res;
                    end
                end else begin
                    case (op_q)
                        OP_SWAP: begin
                            work_d = mem_rd; // see RULE_01
                            mem_d[addr] = work_q; // see RULE_01
                        end
                        OP_PUSH: begin
                            mem_d[sp_q] = work_q; // see RULE_02
                            mem_d[sp_nx] = {4'h0, flags_q}; // see RULE_02
                            sp_d = sp_q + SP_STEP; // see RULE_02
                        end
                        OP_POP: begin
                            sp_d = sp_dn; // see RULE_03
                            work_d = mem_q[sp_dn]; // see RULE_03
                            flags_d = mem_q[sp_dn + 4'h1][3:0]; // see RULE_03
                        end
                        OP_CLR_M: mem_d[addr] = 8'h00; // see RULE_18
                        default: bad_d = 1'b1;
                    endcase
                end
            end
        endcase
    end

    // Datapath state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            op_q <= OP_SWAP;
            opnd_q <= OPND_RST;
            work_q <= WORK_RST;
            flags_q <= FLAGS_RST;
            sp_q <= SP_RST;
            bad_q <= 1'b0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            opnd_q <= opnd_d;
            work_q <= work_d;
            flags_q <= flags_d;
            sp_q <= sp_d;
            bad_q <= bad_d;
        end
    end

    // Data memory holds no reset
    always_ff @(posedge pclk) begin
        mem_q <= mem_d;
    end

    // ****************************************
    // APB read data and handshake
    // ****************************************
    always_comb begin
        rd_val = '0;
        case (sel)
            SEL_CMD: rd_val[4:0] = op_q;
            SEL_OPND: rd_val[11:0] = opnd_q;
            SEL_WORK: rd_val[7:0] = work_q;
            SEL_FLAGS: rd_val[3:0] = flags_q;
            SEL_STACK: rd_val[3:0] = sp_q;
            SEL_MEMWIN: rd_val[7:0] = mem_rd;
            SEL_STATUS: rd_val[STAT_BADOP:STAT_BUSY] = {bad_q, exec};
            default: ;
        endcase
    end

    // One wait cycle, then answer; unmapped addresses error
    always_comb begin
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        if (psel && penable && !pready_q) begin
            pready_d = 1'b1;
            pslverr_d = (sel == SEL_NONE);
            prdata_d = pwrite ? '0 : rd_val;
        end
    end

    // Bus answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // ****************************************
    // Assertions and covers
    // ****************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_swap_exchange: assert property (exec && op_q == OP_SWAP |=> // see RULE_01
        work_q == $past(mem_rd) && mem_q[$past(addr)] == $past(work_q) && $stable(flags_q))
        else $error("swap did not exchange values");
    a_push_store: assert property (exec && op_q == OP_PUSH |=> // see RULE_02
        sp_q == 4'($past(sp_q) + SP_STEP) && mem_q[$past(sp_q)] == $past(work_q) && $stable(flags_q))
        else $error("save did not store or advance");
    a_pop_restore: assert property (exec && op_q == OP_POP |=> // see RULE_03
        sp_q == 4'($past(sp_q) - SP_STEP) && work_q == mem_q[sp_q] && flags_q == mem_q[sp_nx][3:0])
        else $error("restore mismatch");
    a_add_imm: assert property (exec && op_q == OP_ADD_AI |=> // see RULE_04
        work_q == 8'($past(work_q) + $past(imm))) else $error("add immediate wrong");
    a_addc_mem: assert property (exec && op_q == OP_ADDC_MA |=> // see RULE_06
        mem_q[$past(addr)] == 8'($past(mem_rd) + $past(work_q) + {7'h00, $past(flags_q[FLAG_C])}))
        else $error("add with carry to memory wrong");
    a_sub_borrow: assert property (exec && op_q == OP_SUB_AM |=> // see RULE_10
        flags_q[FLAG_C] == ($past(work_q) < $past(mem_rd)) && work_q == 8'($past(work_q) - $past(mem_rd)))
        else $error("subtract or borrow wrong");
    a_subc_mem: assert property (exec && op_q == OP_SUBC_MA |=> // see RULE_13
        mem_q[$past(addr)] == 8'($past(mem_rd) - $past(work_q) - {7'h00, $past(flags_q[FLAG_C])}))
        else $error("subtract with borrow to memory wrong");
    a_inc_mem: assert property (exec && op_q == OP_INC_M |=> // see RULE_16
        mem_q[$past(addr)] == 8'($past(mem_rd) + 8'h01)) else $error("increment wrong");
    a_dec_mem: assert property (exec && op_q == OP_DEC_M |=> // see RULE_17
        mem_q[$past(addr)] == 8'($past(mem_rd) - 8'h01)) else $error("decrement wrong");
    a_clear_mem: assert property (exec && op_q == OP_CLR_M |=> // see RULE_18
        mem_q[$past(addr)] == 8'h00 && $stable(flags_q)) else $error("clear wrong");
    a_zero_flag: assert property (exec && is_arith |=> // see RULE_19
        flags_q[FLAG_Z] == (($past(to_mem) ? mem_q[$past(addr)] : work_q) == 8'h00))
        else $error("zero flag wrong");

    c_push: cover property (exec && op_q == OP_PUSH);
    c_pop: cover property (exec && op_q == OP_POP);
    c_subc_borrow: cover property (exec && op_q == OP_SUBC_M && flags_q[FLAG_C]);
    c_overflow: cover property (exec && is_arith && alu_flags[FLAG_OV]);

endmodule : acc_alu

`default_nettype wire

// ==== dv/apb_host.sv ====
// Purpose: APB master standing in for the host that drives the arithmetic block
// Assumes: One transfer at a time, signals changed only just after a rising edge
// Notes:   A wait that runs past its bound returns with ok low

`timescale 1ns/1ns
`default_nettype none

module apb_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [acc_alu_pkg::ADDR_W-1:0] paddr,
    output logic [acc_alu_pkg::DATA_W-1:0] pwdata,
    input wire logic [acc_alu_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    import acc_alu_pkg::*;

    // ****************************************
    // Idle bus from time zero
    // ****************************************
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end

    // ****************************************
    // One transfer: setup, access held until pready
    // ****************************************
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err, output logic ok);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Bounded wait; answer is taken at the edge that sees pready
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        ok = (pready === 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : apb_host

`default_nettype wire

// ==== dv/testbench.sv ====
// Purpose: Self-checking bench for the accumulator arithmetic block
// Assumes: Expected results come from a local model of the flag conventions
// Notes:   Each operation is set up through the registers, run, then read back

`timescale 1ns/1ns
`default_nettype none

module testbench;
    import acc_alu_pkg::*;

    logic pclk;
    logic presetn;
    logic psel, penable, pwrite, pready, pslverr, err, ok;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    int num_errors;
    int n_compared;

    // ****************************************
    // Design and host
    // ****************************************
    acc_alu uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
                 .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
                   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // Clock at 100 MHz
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ****************************************
    // Reporting
    // ****************************************
    task automatic close_out();
        if (num_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_data

    task automatic chk_err(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t err got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_err

    // ****************************************
    // Bus access
    // ****************************************
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        host.xfer(w, a, d, rdata, err, ok);
        // A missing answer ends the run
        if (ok !== 1'b1) begin
            num_errors++;
            close_out();
        end
    endtask : bus

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk_data(rdata, exp);
        chk_err(err, 1'b0);
    endtask : rd_chk

    // ****************************************
    // Reference model: {work, memory byte, flags}
    // ****************************************
    function automatic logic [19:0] model(input op_t op, input logic [7:0] a, input logic [7:0] m,
                                          input logic [7:0] imm, input logic [3:0] f);
        logic [7:0] x, y;
        logic [8:0] s;
        logic [4:0] h;
        logic [3:0] nf;
        logic cin, sb, tm, ov;
        if (op == OP_SWAP) begin
            return {m, a, f};
        end
        if (op == OP_CLR_M) begin
            return {a, 8'h00, f};
        end
        tm = op inside {OP_ADD_MA, OP_ADDC_MA, OP_ADDC_M, OP_SUB_MA, OP_SUBC_MA, OP_SUBC_M, OP_INC_M, OP_DEC_M};
        sb = op inside {OP_SUB_AI, OP_SUB_AM, OP_SUB_MA, OP_SUBC_AM, OP_SUBC_MA, OP_SUBC_A, OP_SUBC_M, OP_DEC_M};
        cin = f[FLAG_C] & (op inside {OP_ADDC_AM, OP_ADDC_MA, OP_ADDC_A, OP_ADDC_M,
                                      OP_SUBC_AM, OP_SUBC_MA, OP_SUBC_A, OP_SUBC_M});
        x = (op inside {OP_SUB_MA, OP_SUBC_MA, OP_ADDC_M, OP_SUBC_M, OP_INC_M, OP_DEC_M}) ? m : a;
        y = m;
        if (op inside {OP_ADD_AI, OP_SUB_AI}) y = imm;
        if (op inside {OP_ADDC_A, OP_ADDC_M, OP_SUBC_A, OP_SUBC_M}) y = 8'h00;
        if (op inside {OP_INC_M, OP_DEC_M}) y = 8'h01;
        if (op inside {OP_SUB_MA, OP_SUBC_MA}) y = a;
        // Carry and half carry are borrows when subtracting
        s = sb ? {1'b0, x} - {1'b0, y} - {8'h00, cin} : {1'b0, x} + {1'b0, y} + {8'h00, cin};
        h = sb ? {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, cin} : {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
        ov = sb ? (x[7] != y[7]) && (s[7] != x[7]) : (x[7] == y[7]) && (s[7] != x[7]);
        nf = {ov, h[4], s[8], s[7:0] == 8'h00};
        return tm ? {a, s[7:0], nf} : {s[7:0], m, nf};
    endfunction : model

    // Load operands, run one operation, read back all three results
    task automatic run_op(input op_t op, input logic [7:0] a, input logic [7:0] m,
                          input logic [7:0] imm, input logic [3:0] f);
        logic [19:0] e;
        e = model(op, a, m, imm, f);
        bus(1'b1, OFF_OPND, {20'h0, op[3:0], imm});
        bus(1'b1, OFF_MEMWIN, {24'h0, m});
        bus(1'b1, OFF_WORK, {24'h0, a});
        bus(1'b1, OFF_FLAGS, {28'h0, f});
        bus(1'b1, OFF_CMD, {27'h0, op});
        rd_chk(OFF_WORK, {24'h0, e[19:12]});
        rd_chk(OFF_MEMWIN, {24'h0, e[11:4]});
        rd_chk(OFF_FLAGS, {28'h0, e[3:0]});
    endtask : run_op

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        num_errors = 0;
        n_compared = 0;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values
        rd_chk(OFF_WORK, 32'h0000_0000);
        rd_chk(OFF_FLAGS, 32'h0000_0000);
        rd_chk(OFF_STACK, 32'h0000_0000);
        rd_chk(OFF_OPND, 32'h0000_0000);
        // Every arithmetic code at a boundary value
        run_op(OP_SWAP, 8'h3C, 8'hA5, 8'h00, 4'hF);
        run_op(OP_ADD_AI, 8'h7F, 8'h00, 8'h01, 4'h0);
        run_op(OP_ADD_AM, 8'hFF, 8'h01, 8'h00, 4'h0);
        run_op(OP_ADD_MA, 8'h80, 8'h80, 8'h00, 4'h0);
        run_op(OP_ADDC_AM, 8'h0F, 8'h00, 8'h00, 4'h2);
        run_op(OP_ADDC_MA, 8'h7E, 8'h01, 8'h00, 4'h2);
        run_op(OP_ADDC_A, 8'hFF, 8'h33, 8'h00, 4'h2);
        run_op(OP_ADDC_M, 8'h44, 8'h0F, 8'h00, 4'h2);
        run_op(OP_SUB_AI, 8'h05, 8'h00, 8'h06, 4'h0);
        run_op(OP_SUB_AM, 8'h80, 8'h01, 8'h00, 4'h0);
        run_op(OP_SUB_MA, 8'h10, 8'h10, 8'h00, 4'hF);
        run_op(OP_SUBC_AM, 8'h00, 8'h00, 8'h00, 4'h2);
        run_op(OP_SUBC_MA, 8'h01, 8'h12, 8'h00, 4'h2);
        run_op(OP_SUBC_A, 8'h80, 8'h55, 8'h00, 4'h2);
        run_op(OP_SUBC_M, 8'h66, 8'h00, 8'h00, 4'h2);
        run_op(OP_INC_M, 8'h11, 8'hFF, 8'h00, 4'h0);
        run_op(OP_DEC_M, 8'h22, 8'h00, 8'h00, 4'h0);
        run_op(OP_CLR_M, 8'h99, 8'h5A, 8'h00, 4'hF);
        // Save at the top of the stack space, index wraps
        bus(1'b1, OFF_STACK, 32'h0000_000E);
        bus(1'b1, OFF_WORK, 32'h0000_00C3);
        bus(1'b1, OFF_FLAGS, 32'h0000_000A);
        bus(1'b1, OFF_CMD, {27'h0, OP_PUSH});
        rd_chk(OFF_STACK, 32'h0000_0000);
        rd_chk(OFF_FLAGS, 32'h0000_000A);
        bus(1'b1, OFF_OPND, 32'h0000_0E00);
        rd_chk(OFF_MEMWIN, 32'h0000_00C3);
        bus(1'b1, OFF_OPND, 32'h0000_0F00);
        rd_chk(OFF_MEMWIN, 32'h0000_000A);
        // Clobber state, then restore it
        bus(1'b1, OFF_WORK, 32'h0000_0000);
        bus(1'b1, OFF_FLAGS, 32'h0000_0005);
        bus(1'b1, OFF_CMD, {27'h0, OP_POP});
        rd_chk(OFF_STACK, 32'h0000_000E);
        rd_chk(OFF_WORK, 32'h0000_00C3);
        rd_chk(OFF_FLAGS, 32'h0000_000A);
        // Unknown opcode is flagged, unmapped address refused
        bus(1'b1, OFF_CMD, 32'h0000_001F);
        rd_chk(OFF_STATUS, 32'h0000_0002);
        bus(1'b0, 8'h1C, 32'h0000_0000);
        chk_err(err, 1'b1);
        chk_data(rdata, 32'h0000_0000);
        close_out();
    end
endmodule : testbench

`default_nettype wire
